// [design/rtlr_pkg.sv]
// package: offsets, reset values, field layouts and carriers of the bank
package rtlr_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_HIGH_MSB     = 8'h07;
  localparam logic [7:0] IDX_LOW_MSB      = 8'h08;
  localparam logic [7:0] IDX_HIGH_MSB_ALT = 8'h0D;
  localparam logic [7:0] IDX_LOW_MSB_ALT  = 8'h0E;
  localparam logic [7:0] IDX_OFFSET_MSB   = 8'h11;
  localparam logic [7:0] IDX_OFFSET_LSB   = 8'h12;
  localparam logic [7:0] IDX_HIGH_LSB     = 8'h13;
  localparam logic [7:0] IDX_LOW_LSB      = 8'h14;
  localparam logic [7:0] IDX_CRIT         = 8'h19;
  localparam logic [7:0] IDX_CONFIG       = 8'h40;
  localparam logic [7:0] IDX_ENH_CONFIG   = 8'h41;

  // values after reset
  localparam logic [7:0] RST_HIGH_MSB   = 8'h55;
  localparam logic [7:0] RST_LOW_MSB    = 8'h00;
  localparam logic [7:0] RST_OFFSET_MSB = 8'h00;
  localparam logic [2:0] RST_FRACTION   = 3'h0;
  localparam logic [7:0] RST_CRIT       = 8'h6E;
  localparam logic       RST_OVERRIDE   = 1'b1;
  localparam logic       RST_FORMAT_SELECT = 1'b0;

  // field positions
  localparam int FRAC_HI      = 7;   // fraction field is bits 7:5
  localparam int FRAC_LO      = 5;
  localparam int OVERRIDE_BIT = 1;   // in the configuration register
  localparam int FORMAT_SELECT_BIT = 0; // enhanced configuration register

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rtlr_apb_req_t;

  // limits decoded to signed twelfth-bit eighths of a degree
  typedef struct packed {
    logic [11:0] high;
    logic [11:0] low;
    logic [11:0] crit;
  } rtlr_limits_t;

endpackage

// [design/rtlr_offset_adder.sv]
// offset adder: registered reading plus signed offset, saturated
`timescale 1ns/1ps
module rtlr_offset_adder (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic [11:0] reading_in,
  input  wire logic [10:0] offset_in,
  output logic      [11:0] corrected_out
);

  logic [12:0] sum;
  logic [11:0] corrected_ff;
  logic [11:0] nxt_corrected;

  // thirteen-bit sum keeps the carry so overflow can be seen
  assign sum = {reading_in[11], reading_in} +
               {{2{offset_in[10]}}, offset_in};

  // clamp instead of wrapping, a wrap would flip hot into cold
  assign nxt_corrected = (sum[12] == sum[11]) ? sum[11:0] :
                         (sum[12] ? 12'h800 : 12'h7FF);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      corrected_ff <= 12'h000;
    end else begin
      corrected_ff <= nxt_corrected;
    end
  end

  assign corrected_out = corrected_ff;

endmodule

// [design/rtlr_limit_regs.sv]
// register bank for remote offset and limits behind an apb slave
//
// What this block does
// - the signed offset pair is added to the reading, msb resets to 0.
// - offset, high and low lsb bits 4:0 ignore writes and read as 0.
// - high limit is msb plus lsb bits 7:5, reset 85 degrees (0x55).
// - high limit is unsigned or signed as the format select bit says.
// - low limit is signed, msb plus lsb bits 7:5, reset 0 degrees.
// - critical limit is one read-write byte resetting to 0x6E (110).
// - signed format: msb bit 7 sign, bit 0 one degree, lsb 7:5 to 1/8.
// - unsigned format: msb bit 7 weighs 128, fraction bits as signed.
`timescale 1ns/1ps
module rtlr_limit_regs (
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_n_in,
  input  wire rtlr_pkg::rtlr_apb_req_t apb_req_in,
  output logic                        pready_out,
  output logic                        pslverr_out,
  output logic [31:0]                 prdata_out,
  input  wire logic [11:0]            remote_reading_in,
  output logic [11:0]                 corrected_reading_out,
  output rtlr_pkg::rtlr_limits_t      limits_out,
  output logic                        critical_limit_override_out,
  output logic                        unsigned_format_select_out
);

  // msb plus 3-bit fraction to signed eighths; unsigned zero-extends
  function automatic logic [11:0] to_eighths(input logic [7:0] msb,
                                             input logic [2:0] frac,
                                             input logic       unsgn);
    to_eighths = {unsgn ? 1'b0 : msb[7], msb, frac};
  endfunction

  // stored fields
  logic [7:0]  high_limit_upper_bits_ff;
  logic [2:0]  high_limit_fraction_bits_ff;
  logic [7:0]  low_limit_upper_bits_ff;
  logic [2:0]  low_limit_fraction_bits_ff;
  logic [7:0]  remote_offset_bits_ff;
  logic [2:0]  offset_fraction_bits_ff;
  logic [7:0]  critical_limit_bits_ff;
  logic        override_ff;
  logic        unsigned_format_select_ff;
  // bus answer and decoded limits
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  rtlr_pkg::rtlr_limits_t limits_ff;
  rtlr_pkg::rtlr_limits_t nxt_limits;

  // address decode
  wire         setup_phase;
  wire         access_done;
  wire         do_write;
  wire [7:0]   idx;
  wire         addr_ok;
  wire         hit_high_msb;
  wire         hit_low_msb;
  wire         hit_off_msb;
  wire         hit_off_lsb;
  wire         hit_high_lsb;
  wire         hit_low_lsb;
  wire         hit_crit;
  wire         hit_cfg;
  wire         hit_enh;
  wire         mapped;
  wire [7:0]   rd_byte;
  wire [2:0]   wr_frac;
  // per-register write strobes, each true only at a completing write edge
  wire         wr_high_msb;
  wire         wr_high_lsb;
  wire         wr_low_msb;
  wire         wr_low_lsb;
  wire         wr_off_msb;
  wire         wr_off_lsb;
  wire         wr_crit;
  wire         wr_cfg;
  wire         wr_enh;

  assign setup_phase = apb_req_in.psel & ~apb_req_in.penable;
  assign access_done = apb_req_in.psel & apb_req_in.penable & pready_ff;
  assign do_write    = access_done & apb_req_in.pwrite & ~pslverr_ff;
  // only aligned word addresses in the low kilobyte decode
  assign addr_ok     = (apb_req_in.paddr[1:0] == 2'b00) &
                       (apb_req_in.paddr[11:10] == 2'b00);
  assign idx         = apb_req_in.paddr[9:2];

  // primary and alternate indices land on one storage
  assign hit_high_msb = addr_ok & ((idx == rtlr_pkg::IDX_HIGH_MSB) |
                        (idx == rtlr_pkg::IDX_HIGH_MSB_ALT));
  assign hit_low_msb  = addr_ok & ((idx == rtlr_pkg::IDX_LOW_MSB) |
                        (idx == rtlr_pkg::IDX_LOW_MSB_ALT));
  assign hit_off_msb  = addr_ok & (idx == rtlr_pkg::IDX_OFFSET_MSB);
  assign hit_off_lsb  = addr_ok & (idx == rtlr_pkg::IDX_OFFSET_LSB);
  assign hit_high_lsb = addr_ok & (idx == rtlr_pkg::IDX_HIGH_LSB);
  assign hit_low_lsb  = addr_ok & (idx == rtlr_pkg::IDX_LOW_LSB);
  assign hit_crit     = addr_ok & (idx == rtlr_pkg::IDX_CRIT);
  assign hit_cfg      = addr_ok & (idx == rtlr_pkg::IDX_CONFIG);
  assign hit_enh      = addr_ok & (idx == rtlr_pkg::IDX_ENH_CONFIG);
  assign mapped = hit_high_msb | hit_low_msb | hit_off_msb | hit_off_lsb |
                  hit_high_lsb | hit_low_lsb | hit_crit | hit_cfg | hit_enh;

  // only bits 7:5 of a fraction write are kept, the rest is dropped
  assign wr_frac = apb_req_in.pwdata[rtlr_pkg::FRAC_HI:rtlr_pkg::FRAC_LO];

  // strobes gate the decode with the completing access, so a refused
  // or still-waiting transfer can never touch the storage
  assign wr_high_msb = do_write & hit_high_msb;
  assign wr_high_lsb = do_write & hit_high_lsb;
  assign wr_low_msb  = do_write & hit_low_msb;
  assign wr_low_lsb  = do_write & hit_low_lsb;
  assign wr_off_msb  = do_write & hit_off_msb;
  assign wr_off_lsb  = do_write & hit_off_lsb;
  assign wr_crit     = do_write & hit_crit;
  assign wr_cfg      = do_write & hit_cfg;
  assign wr_enh      = do_write & hit_enh;

  // read mux; unused low fraction bits come back as zero
  assign rd_byte =
    hit_high_msb ? high_limit_upper_bits_ff :
    hit_low_msb  ? low_limit_upper_bits_ff :
    hit_off_msb  ? remote_offset_bits_ff :
    hit_off_lsb  ? {offset_fraction_bits_ff, 5'h00} :
    hit_high_lsb ? {high_limit_fraction_bits_ff, 5'h00} :
    hit_low_lsb  ? {low_limit_fraction_bits_ff, 5'h00} :
    hit_crit     ? critical_limit_bits_ff :
    hit_cfg      ? {6'h00, override_ff, 1'b0} :
    hit_enh      ? {7'h00, unsigned_format_select_ff} : 8'h00;

  // answer: read data is caught in setup, pready rises for one access cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup_phase;
      pslverr_ff <= setup_phase & ~mapped;
      if (setup_phase) begin
        prdata_ff <= {24'h00_0000, rd_byte};
      end
    end
  end

  // limit storage; a write lands at the completing access edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      high_limit_upper_bits_ff    <= rtlr_pkg::RST_HIGH_MSB;
      high_limit_fraction_bits_ff <= rtlr_pkg::RST_FRACTION;
      low_limit_upper_bits_ff     <= rtlr_pkg::RST_LOW_MSB;
      low_limit_fraction_bits_ff  <= rtlr_pkg::RST_FRACTION;
      critical_limit_bits_ff      <= rtlr_pkg::RST_CRIT;
    end else begin
      if (wr_high_msb) high_limit_upper_bits_ff <= apb_req_in.pwdata[7:0];
      if (wr_high_lsb) high_limit_fraction_bits_ff <= wr_frac;
      if (wr_low_msb)  low_limit_upper_bits_ff <= apb_req_in.pwdata[7:0];
      if (wr_low_lsb)  low_limit_fraction_bits_ff <= wr_frac;
      if (wr_crit)     critical_limit_bits_ff <= apb_req_in.pwdata[7:0];
    end
  end

  // offset pair; kept apart from the limits, it feeds the adder directly
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      remote_offset_bits_ff   <= rtlr_pkg::RST_OFFSET_MSB;
      offset_fraction_bits_ff <= rtlr_pkg::RST_FRACTION;
    end else begin
      if (wr_off_msb) remote_offset_bits_ff   <= apb_req_in.pwdata[7:0];
      if (wr_off_lsb) offset_fraction_bits_ff <= wr_frac;
    end
  end

  // configuration bits: override flag and format select
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      override_ff               <= rtlr_pkg::RST_OVERRIDE;
      unsigned_format_select_ff <= rtlr_pkg::RST_FORMAT_SELECT;
    end else begin
      if (wr_cfg) begin
        override_ff <= apb_req_in.pwdata[rtlr_pkg::OVERRIDE_BIT];
      end
      if (wr_enh) begin
        unsigned_format_select_ff <=
          apb_req_in.pwdata[rtlr_pkg::FORMAT_SELECT_BIT];
      end
    end
  end

  // limit decode; high and critical follow format select, low is signed
  assign nxt_limits.high = to_eighths(high_limit_upper_bits_ff,
                                      high_limit_fraction_bits_ff,
                                      unsigned_format_select_ff);
  assign nxt_limits.low  = to_eighths(low_limit_upper_bits_ff,
                                      low_limit_fraction_bits_ff,
                                      1'b0);
  assign nxt_limits.crit = to_eighths(critical_limit_bits_ff, 3'h0,
                                      unsigned_format_select_ff);

  // registered so that downstream comparators see flop outputs
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      limits_ff <= '0;
    end else begin
      limits_ff <= nxt_limits;
    end
  end

  // offset pair joins into one eleven-bit signed correction
  rtlr_offset_adder u_offset_adder (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .reading_in    (remote_reading_in),
    .offset_in     ({remote_offset_bits_ff, offset_fraction_bits_ff}),
    .corrected_out (corrected_reading_out)
  );

  assign pready_out                  = pready_ff;
  assign pslverr_out                 = pslverr_ff;
  assign prdata_out                  = prdata_ff;
  assign limits_out                  = limits_ff;
  assign critical_limit_override_out = override_ff;
  assign unsigned_format_select_out  = unsigned_format_select_ff;

endmodule

// [dv/rtlr_limit_regs_assertions.sv]
// checker: port-level properties of the limit register bank
`timescale 1ns/1ps
module rtlr_limit_regs_assertions (
  input wire logic                    clk_sys_in,
  input wire logic                    rst_n_in,
  input wire rtlr_pkg::rtlr_apb_req_t apb_req_in,
  input wire logic                    pready_out,
  input wire logic                    pslverr_out,
  input wire logic [31:0]             prdata_out,
  input wire rtlr_pkg::rtlr_limits_t  limits_out,
  input wire logic                    unsigned_format_select_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // setup cycle decode
  logic setup;
  assign setup = apb_req_in.psel && !apb_req_in.penable;

  property p_answer; setup |=> pready_out; endproperty
  a_answer: assert property (p_answer) else $error("ready missing");
  property p_misalign; setup && apb_req_in.paddr[1:0] != 2'h0
    |=> pslverr_out && prdata_out == 32'h0000_0000; endproperty
  a_misalign: assert property (p_misalign) else $error("no refusal");
  property p_upper; pready_out |-> prdata_out[31:8] == 24'h00_0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits");
  property p_frac; pready_out && !apb_req_in.pwrite && apb_req_in.paddr
    inside {12'h048, 12'h04C, 12'h050} |-> prdata_out[4:0] == 5'h00;
  endproperty
  a_frac: assert property (p_frac) else $error("unused bits");
  property p_low; limits_out.low[11] == limits_out.low[10]; endproperty
  a_low: assert property (p_low) else $error("low sign");
  // the decode uses the format bit one edge older than the limits
  property p_high; limits_out.high[11] ==
    (!$past(unsigned_format_select_out) && limits_out.high[10]);
  endproperty
  a_high: assert property (p_high) else $error("high format");
  property p_crit; limits_out.crit[2:0] == 3'h0 && limits_out.crit[11] ==
    (!$past(unsigned_format_select_out) && limits_out.crit[10]);
  endproperty
  a_crit: assert property (p_crit) else $error("crit format");
  property p_crit_wr; pready_out && apb_req_in.pwrite &&
    apb_req_in.paddr == 12'h064 |-> ##2
    limits_out.crit[10:3] == $past(apb_req_in.pwdata[7:0], 2); endproperty
  a_crit_wr: assert property (p_crit_wr) else $error("crit write");
  property p_rst; $rose(rst_n_in) |=> limits_out.high == 12'h2A8;
  endproperty
  a_rst: assert property (p_rst) else $error("high reset");
endmodule

bind rtlr_limit_regs rtlr_limit_regs_assertions rtlr_limit_regs_assertions_i (
  .clk_sys_in, .rst_n_in, .apb_req_in, .pready_out, .pslverr_out,
  .prdata_out, .limits_out, .unsigned_format_select_out);

// [dv/rtlr_apb_host.sv]
// apb master model standing in for host software
`timescale 1ns/1ps
module rtlr_apb_host (
  input  wire logic               clk_sys_in,
  input  wire logic               pready_in,
  output rtlr_pkg::rtlr_apb_req_t req_out
);
  initial req_out = '0;
  // one transfer, held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    req_out.psel    <= 1'b1;
    req_out.penable <= 1'b0;
    req_out.pwrite  <= w;
    req_out.paddr   <= a;
    req_out.pwdata  <= d;
    @(posedge clk_sys_in);
    req_out.penable <= 1'b1;
    do @(posedge clk_sys_in);
    while (pready_in !== 1'b1);
  endtask
  // released data is inverted so a stale value cannot pass as fresh
  task automatic idle();
    req_out.psel    <= 1'b0;
    req_out.penable <= 1'b0;
    req_out.pwdata  <= ~req_out.pwdata;
    @(posedge clk_sys_in);
  endtask
  // override lifted first, then the new critical limit
  task automatic crit_update(input logic [7:0] v);
    xfer(1'b1, 12'h100, 32'h0000_0000);
    xfer(1'b1, 12'h064, {24'h00_0000, v});
  endtask
endmodule

// [dv/tb.sv]
// testbench: limit register bank driven through the host model
`timescale 1ns/1ps
module tb;
  logic                    clk_sys_in, rst_n_in, pready_out, pslverr_out;
  logic             [11:0] remote_reading_in, corrected_reading_out, r;
  logic             [31:0] prdata_out, d;
  rtlr_pkg::rtlr_apb_req_t apb_req;
  rtlr_pkg::rtlr_limits_t  limits_out;
  logic                    critical_limit_override_out;
  logic                    unsigned_format_select_out;
  logic             [32:0] exp_q[$];
  int                      miscompares, num_checks, cycles;
  logic             [11:0] adr[11] = '{12'h01C, 12'h034, 12'h020, 12'h038,
    12'h044, 12'h048, 12'h04C, 12'h050, 12'h064, 12'h100, 12'h104};
  logic              [7:0] rv[11] = '{8'h55, 8'h55, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h6E, 8'h02, 8'h00};

  rtlr_limit_regs rtlr_limit_regs_i (.clk_sys_in, .rst_n_in,
    .apb_req_in(apb_req), .pready_out, .pslverr_out, .prdata_out,
    .remote_reading_in, .corrected_reading_out, .limits_out,
    .critical_limit_override_out, .unsigned_format_select_out);
  rtlr_apb_host rtlr_apb_host_i (.clk_sys_in, .pready_in(pready_out),
    .req_out(apb_req));

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read answers matched against the oldest expectation
  always @(posedge clk_sys_in)
    if (pready_out === 1'b1 && apb_req.pwrite === 1'b0)
      chk({pslverr_out, prdata_out}, exp_q.pop_front());
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    rtlr_apb_host_i.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic final_report();
    // an answer that never came leaves its note behind
    if (exp_q.size() != 0) miscompares++;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, far above the roughly 150 cycles the run needs
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    remote_reading_in = 12'h000;
    void'($urandom(56178));
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    foreach (adr[i]) rd(adr[i], {25'h000_0000, rv[i]});
    chk({32'h0000_0000, critical_limit_override_out}, 33'h0_0000_0001);
    $display("reset values done");
    // random writes read back through the alias where one exists
    for (int i = 0; i < 12; i++) begin
      r = adr[i % 8];
      d = $urandom;
      rtlr_apb_host_i.xfer(1'b1, r, d);
      rd(adr[(i % 8) ^ int'(i % 8 < 4)], {25'h000_0000, d[7:5],
        r > 12'h044 ? 5'h00 : d[4:0]});
    end
    // refused addresses keep the stored value
    rtlr_apb_host_i.xfer(1'b1, 12'h01C, 32'h0000_0011);
    foreach (adr[i]) if (i < 3) begin
      rtlr_apb_host_i.xfer(1'b1, 12'h41C - 12'(i), 32'hFFFF_FFFF);
      rd(12'h00C + 12'(i), {1'b1, 32'h0000_0000});
    end
    rd(12'h01C, 33'h0_0000_0011);
    $display("alias and refusal done");
    for (int u = 0; u < 2; u++) begin
      d = $urandom;
      rtlr_apb_host_i.xfer(1'b1, 12'h104, 32'(u));
      rtlr_apb_host_i.xfer(1'b1, 12'h01C, {24'h00_0000, d[15:8]});
      rtlr_apb_host_i.xfer(1'b1, 12'h04C, {24'h00_0000, d[23:16]});
      rtlr_apb_host_i.crit_update(d[7:0]);
      rd(12'h064, {25'h000_0000, d[7:0]});
      chk({21'h00_0000, limits_out.crit},
        {21'h00_0000, u ? 1'b0 : d[7], d[7:0], 3'h0});
      chk({21'h00_0000, limits_out.high},
        {21'h00_0000, u ? 1'b0 : d[15], d[15:8], d[23:21]});
      chk({31'h0000_0000, critical_limit_override_out,
        unsigned_format_select_out}, {32'h0000_0000, u[0]});
    end
    $display("critical limit done");
    // offset of -1.375 degrees, last reading saturates
    rtlr_apb_host_i.xfer(1'b1, 12'h044, 32'h0000_00FE);
    rtlr_apb_host_i.xfer(1'b1, 12'h048, 32'h0000_00A0);
    rtlr_apb_host_i.idle();
    for (int i = 0; i < 8; i++) begin
      r = (i == 7) ? 12'h800 : 12'($urandom_range(0, 1000));
      remote_reading_in <= r;
      repeat (2) @(posedge clk_sys_in);
      chk({21'h00_0000, corrected_reading_out},
        {21'h00_0000, i == 7 ? 12'h800 : r - 12'h00B});
    end
    $display("offset done");
    rtlr_apb_host_i.idle();
    final_report();
  end
endmodule
